// ### rtl/mccu_pkg.sv
// constants and types of the mac control word, upper part
// assumes one 100 MHz clock and an axi4-lite register port
// Overview of operation
// - set excessive-collision flag when a frame is dropped after 16 collided retries
// - set late-collision flag, bit 12, on collision after 64 bytes; frame dropped
// - both collision flags clear on hardware reset or finished soft reset
// - software writes bit 13 to start soft reset; stays 1 until sequence ends
// - soft reset lets the running frame finish, then disables both datapaths
// - in the cycle it disables them, soft reset flushes the receive fifo and clears statistics
// - hash source bit 14 at 0 hashes all 48 destination address bits
// - hash source bit 14 at 1 hashes only the low 24 address bits
// - loopback bit 15 turns transmit frames back into receive at the media interface
// - address choice bits 16-18 act only while source overwrite is set
// - choice 000, the reset value, inserts the primary station address
// - choice 100 inserts supplementary slot 0, 101 inserts slot 1
// - choice 110 inserts supplementary slot 2
// - bit 19 enables magic packet detection on the receive path
// - sleep bit 20 is accepted only while magic detection is enabled
// - wake flag bit 21 is read-only, resets to 0, meaningful with magic enabled
// - wake flag sets on a magic packet, clears when sleep is written 0
// - small-mac build drops loopback, magic detection and sleep controls
package mccu_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h08;
  localparam int BIT_OVR   = 9;
  localparam int BIT_EXC   = 11;
  localparam int BIT_LATE  = 12;
  localparam int BIT_RST   = 13;
  localparam int BIT_HASH  = 14;
  localparam int BIT_LOOP  = 15;
  localparam int BIT_SEL   = 16;
  localparam int BIT_MAGIC = 19;
  localparam int BIT_SLEEP = 20;
  localparam int BIT_WAKE  = 21;
  localparam logic [2:0] SEL_PRIMARY = 3'h0;
  localparam logic [2:0] SEL_RESET   = 3'h0;
  localparam logic [47:0] HASH_LOW_MASK = 48'h000000FFFFFF;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_DRAIN, SEQ_FLUSH, SEQ_DONE} mccu_seq_e;
  typedef struct packed {
    logic       loop_on;
    logic       magic_on;
    logic       sleep_on;
    logic       hash_sel;
    logic       addr_ovr;
    logic [2:0] addr_sel;
  } mccu_ctrl_s;
  localparam mccu_ctrl_s CTRL_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, SEL_RESET};
endpackage

// ### rtl/mccu_flag.sv
// one sticky status flag: hardware sets, a clear request drops it
// assumes set and clear are single-clock requests on CLK
`timescale 1ns/1ps
`default_nettype none
module mccu_flag (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // requests
  input  wire logic set,
  input  wire logic clr,
  // state
  output var  logic q
);
  // set wins so an event in the clearing cycle is kept
  wire logic next_q = set | (q & ~clr);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= 1'b0;
    end else begin
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

// ### rtl/mccu_top.sv
// control word of the mac: collision flags, soft reset, hash source,
// loopback, source address insertion, magic packet sleep and wake
// assumes datapath status inputs synchronous to CLK; axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
module mccu_top #(
  parameter bit SMALL_MAC = 1'b0
) (
  // clock and reset
  input  wire logic               CLK,
  input  wire logic               SYS_RST,
  // axi4-lite write
  input  wire logic [7:0]         S_AXI_AWADDR,
  input  wire logic               S_AXI_AWVALID,
  output var  logic               S_AXI_AWREADY,
  input  wire logic [31:0]        S_AXI_WDATA,
  input  wire logic [3:0]         S_AXI_WSTRB,
  input  wire logic               S_AXI_WVALID,
  output var  logic               S_AXI_WREADY,
  output var  logic [1:0]         S_AXI_BRESP,
  output var  logic               S_AXI_BVALID,
  input  wire logic               S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [7:0]         S_AXI_ARADDR,
  input  wire logic               S_AXI_ARVALID,
  output var  logic               S_AXI_ARREADY,
  output var  logic [31:0]        S_AXI_RDATA,
  output var  logic [1:0]         S_AXI_RRESP,
  output var  logic               S_AXI_RVALID,
  input  wire logic               S_AXI_RREADY,
  // datapath events and status
  input  wire logic               TX_EXCESS_COLL,
  input  wire logic               TX_LATE_COLL,
  input  wire logic               TX_BUSY,
  input  wire logic               RX_BUSY,
  input  wire logic               MAGIC_SEEN,
  // soft reset sequence
  output var  logic               DP_ENABLE,
  output var  logic               RX_FIFO_FLUSH,
  output var  logic               STATS_CLEAR,
  // configuration to the datapath
  output var  mccu_pkg::mccu_ctrl_s CTRL,
  // multicast hash source
  input  wire logic [47:0]        DEST_ADDR,
  output var  logic [47:0]        HASH_KEY,
  // source address insertion
  input  wire logic [47:0]        PRIMARY_ADDR,
  input  wire logic [3:0][47:0]   SUPP_ADDR,
  output var  logic               INSERT_EN,
  output var  logic [47:0]        INSERT_ADDR
);
  mccu_pkg::mccu_ctrl_s ctrl;
  mccu_pkg::mccu_seq_e  seq;
  logic                 rst_req;
  logic                 exc_flag;
  logic                 late_flag;
  logic                 wake_flag;
  logic                 aw_got;
  logic                 w_got;
  logic [7:0]           aw_addr;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;

  // write channel: address and data taken in either order
  wire logic aw_fire = S_AXI_AWVALID & S_AXI_AWREADY;
  wire logic w_fire  = S_AXI_WVALID & S_AXI_WREADY;
  wire logic wr_go   = aw_got & w_got & ~S_AXI_BVALID;
  wire logic wr_hit  = wr_go & (aw_addr == mccu_pkg::CTRL_OFFSET);
  assign S_AXI_AWREADY = ~aw_got;
  assign S_AXI_WREADY  = ~w_got;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw_got  <= 1'b0;
      aw_addr <= 8'h00;
    end else if (aw_fire) begin
      aw_got  <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
    end else if (wr_go) begin
      aw_got  <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      w_got  <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (w_fire) begin
      w_got  <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end else if (wr_go) begin
      w_got  <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= mccu_pkg::RESP_OKAY;
    end else if (wr_go) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_hit ? mccu_pkg::RESP_OKAY : mccu_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // readback word; flags and the soft reset bit show live state
  wire logic [31:0] word;
  assign word = {10'h000, wake_flag, ctrl.sleep_on, ctrl.magic_on, ctrl.addr_sel,
                 ctrl.loop_on, ctrl.hash_sel, rst_req, late_flag, exc_flag,
                 1'b0, ctrl.addr_ovr, 9'h000};

  // byte strobes merge the written bytes into the current word
  wire logic [31:0] strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire logic [31:0] wr_word   = (word & ~strb_mask) | (w_data & strb_mask);

  // read channel: one read under way, answered the cycle after it is taken
  wire logic ar_fire = S_AXI_ARVALID & S_AXI_ARREADY;
  wire logic rd_hit  = (S_AXI_ARADDR == mccu_pkg::CTRL_OFFSET);
  assign S_AXI_ARREADY = ~S_AXI_RVALID;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h00000000;
      S_AXI_RRESP  <= mccu_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_hit ? word : 32'h00000000;
      S_AXI_RRESP  <= rd_hit ? mccu_pkg::RESP_OKAY : mccu_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // control fields; the small build has no loopback, magic or sleep
  wire logic new_magic = wr_word[mccu_pkg::BIT_MAGIC] & ~SMALL_MAC;
  wire logic new_sleep = wr_word[mccu_pkg::BIT_SLEEP] & new_magic;
  wire logic new_loop  = wr_word[mccu_pkg::BIT_LOOP] & ~SMALL_MAC;
  wire logic sleep_off = wr_hit & ~wr_word[mccu_pkg::BIT_SLEEP];
  mccu_pkg::mccu_ctrl_s next_ctrl;
  assign next_ctrl = '{new_loop, new_magic, new_sleep,
                       wr_word[mccu_pkg::BIT_HASH],
                       wr_word[mccu_pkg::BIT_OVR],
                       wr_word[mccu_pkg::BIT_SEL +: 3]};

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl <= mccu_pkg::CTRL_RESET;
    end else if (wr_hit) begin
      ctrl <= next_ctrl;
    end
  end

  // soft reset sequence
  wire logic start_rst = wr_hit & wr_word[mccu_pkg::BIT_RST] & (seq == mccu_pkg::SEQ_IDLE);
  wire logic seq_done  = (seq == mccu_pkg::SEQ_DONE);
  mccu_pkg::mccu_seq_e next_seq;

  always_comb begin
    next_seq = seq;
    case (seq)
      mccu_pkg::SEQ_IDLE: begin
        if (start_rst) begin
          next_seq = mccu_pkg::SEQ_DRAIN;
        end
      end
      mccu_pkg::SEQ_DRAIN: begin
        // a frame in flight finishes before the datapaths go down
        if (!TX_BUSY && !RX_BUSY) begin
          next_seq = mccu_pkg::SEQ_FLUSH;
        end
      end
      mccu_pkg::SEQ_FLUSH: begin
        next_seq = mccu_pkg::SEQ_DONE;
      end
      mccu_pkg::SEQ_DONE: begin
        next_seq = mccu_pkg::SEQ_IDLE;
      end
      default: begin
        next_seq = mccu_pkg::SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      seq <= mccu_pkg::SEQ_IDLE;
    end else begin
      seq <= next_seq;
    end
  end

  // request bit ignores writes of 0 while the sequence runs
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rst_req <= 1'b0;
    end else if (start_rst) begin
      rst_req <= 1'b1;
    end else if (seq_done) begin
      rst_req <= 1'b0;
    end
  end

  assign DP_ENABLE     = (seq == mccu_pkg::SEQ_IDLE) | (seq == mccu_pkg::SEQ_DRAIN);
  assign RX_FIFO_FLUSH = (seq == mccu_pkg::SEQ_FLUSH);
  assign STATS_CLEAR   = (seq == mccu_pkg::SEQ_FLUSH);

  // status flags
  mccu_flag u_exc (
    .clk (CLK),
    .rst (SYS_RST),
    .set (TX_EXCESS_COLL),
    .clr (seq_done),
    .q   (exc_flag)
  );

  mccu_flag u_late (
    .clk (CLK),
    .rst (SYS_RST),
    .set (TX_LATE_COLL),
    .clr (seq_done),
    .q   (late_flag)
  );

  mccu_flag u_wake (
    .clk (CLK),
    .rst (SYS_RST),
    .set (MAGIC_SEEN & ctrl.magic_on),
    .clr (sleep_off),
    .q   (wake_flag)
  );

  assign CTRL = ctrl;

  // hash key: upper half zeroed when hashing low bits only
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      HASH_KEY <= 48'h000000000000;
    end else if (ctrl.hash_sel) begin
      HASH_KEY <= DEST_ADDR & mccu_pkg::HASH_LOW_MASK;
    end else begin
      HASH_KEY <= DEST_ADDR;
    end
  end

  // source address: 000 primary, 1xx supplementary slot xx, 001-011 none
  wire logic sel_supp  = ctrl.addr_sel[2];
  wire logic sel_valid = sel_supp | (ctrl.addr_sel == mccu_pkg::SEL_PRIMARY);
  wire logic [47:0] sel_addr = sel_supp ? SUPP_ADDR[ctrl.addr_sel[1:0]] : PRIMARY_ADDR;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      INSERT_EN   <= 1'b0;
      INSERT_ADDR <= 48'h000000000000;
    end else begin
      INSERT_EN   <= ctrl.addr_ovr & sel_valid;
      INSERT_ADDR <= sel_addr;
    end
  end

  AST_EXC_SET: assert property (@(posedge CLK) disable iff (SYS_RST)
    TX_EXCESS_COLL |=> exc_flag)
    else $error("excessive collision flag not set");

  AST_EXC_HOLD: assert property (@(posedge CLK) disable iff (SYS_RST)
    exc_flag && !seq_done |=> exc_flag)
    else $error("excessive collision flag lost before reset");

  AST_LATE_SET: assert property (@(posedge CLK) disable iff (SYS_RST)
    TX_LATE_COLL |=> late_flag && word[mccu_pkg::BIT_LATE])
    else $error("late collision flag not set");

  AST_LATE_HOLD: assert property (@(posedge CLK) disable iff (SYS_RST)
    late_flag && !seq_done |=> late_flag)
    else $error("late collision flag lost before reset");

  AST_FLAGS_CLR: assert property (@(posedge CLK) disable iff (SYS_RST)
    seq_done && !TX_EXCESS_COLL && !TX_LATE_COLL |=> !exc_flag && !late_flag)
    else $error("collision flags survive soft reset");

  AST_REQ_HELD: assert property (@(posedge CLK) disable iff (SYS_RST)
    rst_req && !seq_done |=> rst_req)
    else $error("soft reset request dropped early");

  AST_REQ_DONE: assert property (@(posedge CLK) disable iff (SYS_RST)
    seq_done |=> !rst_req)
    else $error("soft reset request not cleared at end of sequence");

  AST_START: assert property (@(posedge CLK) disable iff (SYS_RST)
    start_rst |=> rst_req && DP_ENABLE && (seq == mccu_pkg::SEQ_DRAIN))
    else $error("soft reset did not start by draining");

  AST_DRAIN: assert property (@(posedge CLK) disable iff (SYS_RST)
    (seq == mccu_pkg::SEQ_DRAIN) && (TX_BUSY || RX_BUSY) |-> DP_ENABLE ##1 DP_ENABLE)
    else $error("datapath disabled during a frame");

  AST_FLUSH: assert property (@(posedge CLK) disable iff (SYS_RST)
    RX_FIFO_FLUSH |-> !DP_ENABLE && STATS_CLEAR ##1 !RX_FIFO_FLUSH && rst_req ##1 !rst_req)
    else $error("flush step out of order");

  // gated on the sampled reset: the release edge still loads a cleared key
  AST_HASH: assert property (@(posedge CLK) disable iff (SYS_RST)
    !SYS_RST |=> HASH_KEY == ($past(ctrl.hash_sel) ? ($past(DEST_ADDR) & mccu_pkg::HASH_LOW_MASK)
                                                   : $past(DEST_ADDR)))
    else $error("hash key source wrong");

  AST_INSERT: assert property (@(posedge CLK) disable iff (SYS_RST)
    !ctrl.addr_ovr || (ctrl.addr_sel inside {3'h1, 3'h2, 3'h3}) |=> !INSERT_EN)
    else $error("address inserted when not allowed");

  AST_PRIMARY: assert property (@(posedge CLK) disable iff (SYS_RST)
    !SYS_RST && ctrl.addr_ovr && (ctrl.addr_sel == mccu_pkg::SEL_PRIMARY) |=>
      INSERT_EN && (INSERT_ADDR == $past(PRIMARY_ADDR)))
    else $error("primary address not inserted");

  AST_SLEEP: assert property (@(posedge CLK) disable iff (SYS_RST)
    ctrl.sleep_on |-> ctrl.magic_on)
    else $error("sleep without magic detection");

  AST_WAKE: assert property (@(posedge CLK) disable iff (SYS_RST)
    MAGIC_SEEN && ctrl.magic_on |=> wake_flag)
    else $error("wake flag not set on magic packet");

  AST_WAKE_CLR: assert property (@(posedge CLK) disable iff (SYS_RST)
    sleep_off && !(MAGIC_SEEN && ctrl.magic_on) |=> !wake_flag)
    else $error("wake flag not cleared by sleep write of 0");

  CVR_SOFT_RESET: cover property (@(posedge CLK) disable iff (SYS_RST)
    start_rst ##[1:20] seq_done);
  CVR_WAKE: cover property (@(posedge CLK) disable iff (SYS_RST)
    ctrl.sleep_on && wake_flag);
  CVR_INSERT_SUPP: cover property (@(posedge CLK) disable iff (SYS_RST)
    INSERT_EN && sel_supp);
  CVR_DRAIN_WAIT: cover property (@(posedge CLK) disable iff (SYS_RST)
    (seq == mccu_pkg::SEQ_DRAIN) && (TX_BUSY || RX_BUSY));
  CVR_RESERVED: cover property (@(posedge CLK) disable iff (SYS_RST)
    ctrl.addr_ovr && !sel_valid);
endmodule
`default_nettype wire

// ### tb/mccu_top_tb_top.sv
// bench for the mac control word: axi4-lite tasks and directed tests
// assumes the design package and top are compiled first
`timescale 1ns/1ps
`default_nettype none
module mccu_top_tb_top;
  logic                 CLK = 1'b0;
  logic                 SYS_RST = 1'b1;
  logic [7:0]           awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]          wdata = 32'h0;
  logic [3:0]           wstrb = 4'hF;
  logic                 awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic                 exc = 1'b0, late = 1'b0, txb = 1'b0, rxb = 1'b0, magic = 1'b0;
  logic [47:0]          dest = 48'h0;
  logic [47:0]          prim = 48'h0A0B0C0D0E0F;
  logic [3:0][47:0]     supp = {48'h333333333333, 48'h222222222222, 48'h111111111111, 48'h101010101010};
  logic                 awready, wready, bvalid, arready, rvalid, dp_en, flush, stclr, ins_en;
  logic [1:0]           bresp, rresp;
  logic [31:0]          rdata;
  logic [47:0]          hkey, ins_addr;
  mccu_pkg::mccu_ctrl_s ctrl;
  int                   err_total = 0;
  int                   tests_run = 0;

  mccu_top u_mccu_top (.CLK(CLK), .SYS_RST(SYS_RST),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .TX_EXCESS_COLL(exc), .TX_LATE_COLL(late), .TX_BUSY(txb), .RX_BUSY(rxb),
    .MAGIC_SEEN(magic), .DP_ENABLE(dp_en), .RX_FIFO_FLUSH(flush), .STATS_CLEAR(stclr), .CTRL(ctrl),
    .DEST_ADDR(dest), .HASH_KEY(hkey), .PRIMARY_ADDR(prim), .SUPP_ADDR(supp), .INSERT_EN(ins_en),
    .INSERT_ADDR(ins_addr));

  always #5 CLK = ~CLK;

  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
  endtask

  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // each channel is released at the edge where its ready was seen high
  // bready and rready stay high once raised, so a following call never re-raises them in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge CLK);
      aw_ok = aw_ok || awready;
      w_ok = w_ok || wready;
      awvalid <= !aw_ok;
      wvalid <= !w_ok;
    end
    do @(posedge CLK); while (!bvalid);
    check("bresp", 48'(bresp), 48'(er));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge CLK); while (!arready);
    arvalid <= 1'b0;
    do @(posedge CLK); while (!rvalid);
    check("rdata", 48'(rdata), 48'(ed));
    check("rresp", 48'(rresp), 48'(er));
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  initial begin
    #200000;
    err_total++;
    final_report();
  end

  initial begin
    tick(5);
    SYS_RST <= 1'b0;
    tick(1);
    rd(8'h08, 32'h0, 2'h0);
    done("reset");
    exc <= 1'b1;
    tick(1);
    exc <= 1'b0;
    late <= 1'b1;
    tick(1);
    late <= 1'b0;
    rd(8'h08, 32'h1800, 2'h0);
    done("collision");
    txb <= 1'b1;
    rxb <= 1'b1;
    wr(8'h08, 32'h2000, 4'hF, 2'h0);
    tick(4);
    txb <= 1'b0;
    rd(8'h08, 32'h3800, 2'h0);
    check("dp_enable", 48'(dp_en), 48'h1);
    check("flush", 48'(flush), 48'h0);
    rxb <= 1'b0;
    do @(posedge CLK); while (!flush);
    check("dp_enable", 48'(dp_en), 48'h0);
    check("stats_clear", 48'(stclr), 48'h1);
    tick(3);
    rd(8'h08, 32'h0, 2'h0);
    done("soft_reset");
    wr(8'h08, 32'h4000, 4'hF, 2'h0);
    dest <= 48'hA1B2C3D4E5F6;
    tick(2);
    check("hash_key", hkey, 48'h000000D4E5F6);
    wr(8'h08, 32'h8000, 4'hF, 2'h0);
    tick(2);
    check("hash_key", hkey, 48'hA1B2C3D4E5F6);
    check("loop_on", 48'(ctrl.loop_on), 48'h1);
    rd(8'h08, 32'h8000, 2'h0);
    done("hash_loop");
    for (int c = 0; c < 8; c++) begin
      wr(8'h08, 32'h200 | 32'(c << 16), 4'hF, 2'h0);
      tick(2);
      check("insert_en", 48'(ins_en), 48'((c == 0) || (c >= 4)));
      if (c == 0) check("insert_addr", ins_addr, prim);
      if (c >= 4) check("insert_addr", ins_addr, supp[c % 4]);
    end
    // only byte 2 is strobed, so the overwrite bit must survive
    wr(8'h08, 32'h0, 4'h4, 2'h0);
    rd(8'h08, 32'h200, 2'h0);
    wr(8'h08, 32'h70000, 4'hF, 2'h0);
    tick(2);
    check("insert_en", 48'(ins_en), 48'h0);
    done("source_addr");
    wr(8'h08, 32'h100000, 4'hF, 2'h0);
    rd(8'h08, 32'h0, 2'h0);
    check("sleep_on", 48'(ctrl.sleep_on), 48'h0);
    wr(8'h08, 32'h180000, 4'hF, 2'h0);
    check("magic_on", 48'(ctrl.magic_on), 48'h1);
    check("sleep_on", 48'(ctrl.sleep_on), 48'h1);
    magic <= 1'b1;
    tick(1);
    magic <= 1'b0;
    rd(8'h08, 32'h380000, 2'h0);
    wr(8'h08, 32'h80000, 4'hF, 2'h0);
    rd(8'h08, 32'h80000, 2'h0);
    done("sleep_wake");
    rd(8'h0C, 32'h0, 2'h2);
    wr(8'h0C, 32'hFFFFFFFF, 4'hF, 2'h2);
    rd(8'h08, 32'h80000, 2'h0);
    done("unmapped");
    exc <= 1'b1;
    tick(1);
    exc <= 1'b0;
    rd(8'h08, 32'h80800, 2'h0);
    SYS_RST <= 1'b1;
    tick(2);
    SYS_RST <= 1'b0;
    tick(1);
    rd(8'h08, 32'h0, 2'h0);
    done("hw_reset");
    final_report();
  end
endmodule
`default_nettype wire
